/* File: hdl/scss_consts.vh */
/*
 * Constants for the startup, calibration-transfer and self-test sequencer:
 * register offsets, field positions, status codes, reset values, timing.
 * Assumes nothing; definitions only.
 */
`ifndef SCSS_CONSTS_VH
`define SCSS_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define SCSS_REG_CTRL        12'h000
`define SCSS_REG_STATUS      12'h004
`define SCSS_REG_RESULT      12'h008
`define SCSS_REG_SETTINGS    12'h00c
`define SCSS_REG_CAL_COUNT   12'h010

// ****************************************
// control register bits (write 1 to act)
// ****************************************
`define SCSS_CTRL_INIT_BIT     0
`define SCSS_CTRL_SELFTEST_BIT 1
`define SCSS_CTRL_DISP_ON_BIT  2
`define SCSS_CTRL_DISP_OFF_BIT 3

// ****************************************
// status codes shown to the display
// ****************************************
`define SCSS_ST_NONE          5'h00
`define SCSS_ST_WAIT_FLOAT    5'h01
`define SCSS_ST_RETAINED      5'h02
`define SCSS_ST_INITIALISED   5'h03
`define SCSS_ST_MAINS_FAULT   5'h04
`define SCSS_ST_XFER_FAIL     5'h05
`define SCSS_ST_PAGE_ONE_BAD  5'h06
`define SCSS_ST_DEFAULTS_USED 5'h07
`define SCSS_ST_DISPLAY_OFF   5'h08
`define SCSS_ST_FLOAT_FAULT   5'h09
`define SCSS_ST_TEST_BASE     5'h10
`define SCSS_ST_FAIL_BASE     5'h14
`define SCSS_ST_PASS          5'h18

// ****************************************
// default settings: dc volts, autorange, 6x9
// ****************************************
`define SCSS_FUNC_DCV        2'h0
`define SCSS_SCALE_6X9       2'h1

// ****************************************
// checksum and timing
// ****************************************
`define SCSS_CSUM_OFFSET     8'h5a
`define SCSS_FLOAT_WAIT_US   100
`define SCSS_CLK_MHZ         200
`define SCSS_FLOAT_WAIT_CYC  (`SCSS_FLOAT_WAIT_US * `SCSS_CLK_MHZ)

`endif

/* File: hdl/scss_sequencer.v */
/*
 * Startup sequencer: power-up checks, calibration copy from a two-page
 * non-volatile store into backed RAM with checksum and fallback, and an
 * ordered four-stage self test. Status code is held for the display.
 * Assumes one 200 MHz clock, synchronous inputs, an APB master, a store
 * that answers a read one cycle after its strobe, and a RAM with a
 * one-cycle write and a one-cycle-latency validity check per word.
 */
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "scss_consts.vh"

module scss_sequencer #(
    parameter AW         = 6,
    parameter NCONST     = 48,
    parameter FLOAT_WAIT = `SCSS_FLOAT_WAIT_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        float_out_of_reset,
    input  wire        mains_freq_found,
    input  wire        backup_retained,
    output reg         nvm_rd,
    output reg         nvm_page,
    output reg  [AW-1:0] nvm_addr,
    input  wire [7:0]  nvm_data,
    output reg         ram_we,
    output reg  [AW-1:0] ram_addr,
    output reg  [7:0]  ram_wdata,
    output reg         ram_use_default,
    input  wire        ram_word_bad,
    input  wire [AW:0] ram_word_count,
    output reg         test_start,
    output reg  [1:0]  test_stage,
    input  wire        test_done,
    input  wire        test_pass,
    output reg  [4:0]  status_code,
    output reg         display_on,
    output reg  [1:0]  meas_func,
    output reg         autorange,
    output reg  [1:0]  scale_len,
    output reg         unusable,
    output reg         dc_only,
    output reg         busy
);

    // ****************************************
    // state machine, one-hot
    // ****************************************
    localparam [9:0] S_IDLE  = 10'h001;
    localparam [9:0] S_FLOAT = 10'h002;
    localparam [9:0] S_MAINS = 10'h004;
    localparam [9:0] S_READ  = 10'h008;
    localparam [9:0] S_CHECK = 10'h010;
    localparam [9:0] S_COPY  = 10'h020;
    localparam [9:0] S_COUNT = 10'h040;
    localparam [9:0] S_DONE  = 10'h080;
    localparam [9:0] S_TEST  = 10'h100;
    localparam [9:0] S_TWAIT = 10'h200;

    localparam integer  LAST_I = NCONST - 1;
    localparam [AW-1:0] LAST   = LAST_I[AW-1:0];

    reg [9:0]    state;
    reg          started;
    reg [31:0]   wait_cnt;
    reg [7:0]    csum;
    reg          page_one_bad;
    reg          xfer_bad;
    reg          defaults;
    reg          rd_pend;
    reg          chk_pend;
    reg          init_req;
    reg          test_req;
    reg          by_init;

    // apb decode helper
    function is_reg;
        input [11:0] a;
        input [11:0] r;
        begin
            is_reg = (a == r);
        end
    endfunction

    wire acc = psel & penable & pready;
    wire wr  = acc & pwrite;
    wire wr_ctrl = wr & is_reg(paddr, `SCSS_REG_CTRL);

    // ****************************************
    // apb slave: one wait state, reads latched
    // ****************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~(is_reg(paddr, `SCSS_REG_CTRL) |
                       is_reg(paddr, `SCSS_REG_STATUS) | is_reg(paddr, `SCSS_REG_RESULT) |
                       is_reg(paddr, `SCSS_REG_SETTINGS) | is_reg(paddr, `SCSS_REG_CAL_COUNT));
            if (psel & penable & ~pready & ~pwrite)
            begin
                if (is_reg(paddr, `SCSS_REG_STATUS))
                    prdata <= {22'h0, busy, unusable, dc_only, page_one_bad, xfer_bad,
                               defaults, display_on, status_code[3:0] == 4'h0 ? 1'b0 : 1'b1,
                               2'h0};
                else if (is_reg(paddr, `SCSS_REG_RESULT))
                    prdata <= {27'h0, status_code};
                else if (is_reg(paddr, `SCSS_REG_SETTINGS))
                    prdata <= {27'h0, scale_len, autorange, meas_func};
                else if (is_reg(paddr, `SCSS_REG_CAL_COUNT))
                    prdata <= {{(31-AW){1'b0}}, ram_word_count};
                else
                    prdata <= 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // main sequencer
    // ****************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= S_IDLE;        started <= 1'b0;       wait_cnt <= 32'h0;
            csum <= 8'h00;          page_one_bad <= 1'b0;  xfer_bad <= 1'b0;
            defaults <= 1'b0;       rd_pend <= 1'b0;       chk_pend <= 1'b0;
            init_req <= 1'b0;       test_req <= 1'b0;      by_init <= 1'b0;
            nvm_rd <= 1'b0;         nvm_page <= 1'b0;      nvm_addr <= {AW{1'b0}};
            ram_we <= 1'b0;         ram_addr <= {AW{1'b0}}; ram_wdata <= 8'h00;
            ram_use_default <= 1'b0; test_start <= 1'b0;   test_stage <= 2'h0;
            status_code <= `SCSS_ST_NONE; display_on <= 1'b1;
            meas_func <= `SCSS_FUNC_DCV; autorange <= 1'b1; scale_len <= `SCSS_SCALE_6X9;
            unusable <= 1'b0;       dc_only <= 1'b0;       busy <= 1'b0;
        end
        else
        begin
            nvm_rd <= 1'b0;
            ram_we <= 1'b0;
            ram_use_default <= 1'b0;
            test_start <= 1'b0;
            rd_pend <= nvm_rd;
            chk_pend <= ram_we;
            // requests latch until the sequencer is idle
            if (wr_ctrl & pwdata[`SCSS_CTRL_INIT_BIT])
                init_req <= 1'b1;
            if (wr_ctrl & pwdata[`SCSS_CTRL_SELFTEST_BIT])
                test_req <= 1'b1;
            if (wr_ctrl & pwdata[`SCSS_CTRL_DISP_ON_BIT])
                display_on <= 1'b1;
            else if (wr_ctrl & pwdata[`SCSS_CTRL_DISP_OFF_BIT])
                display_on <= 1'b0;
            if (chk_pend & ram_word_bad)
            begin
                ram_we <= 1'b1;
                ram_use_default <= 1'b1;
                defaults <= 1'b1;
            end
            case (state)
            S_IDLE:
            begin
                busy <= 1'b0;
                if (!started | init_req)
                begin
                    if (init_req)
                        display_on <= 1'b1;
                    started <= 1'b1;
                    by_init <= init_req; // an init run never reports retained
                    init_req <= 1'b0;
                    busy <= 1'b1;
                    page_one_bad <= 1'b0;
                    xfer_bad <= 1'b0;
                    defaults <= 1'b0;
                    wait_cnt <= 32'h0;
                    // waiting status; new sequence replaces old code
                    status_code <= `SCSS_ST_WAIT_FLOAT;
                    state <= S_FLOAT;
                end
                else if (test_req)
                begin
                    test_req <= 1'b0;
                    busy <= 1'b1;
                    unusable <= 1'b0;
                    dc_only <= 1'b0;
                    test_stage <= 2'h0;
                    state <= S_TEST;
                end
            end
            S_FLOAT:
            begin
                wait_cnt <= wait_cnt + 32'h1;
                // clear when processor out of reset, fault on timeout
                if (float_out_of_reset)
                begin
                    status_code <= `SCSS_ST_NONE;
                    state <= S_MAINS;
                end
                else if (wait_cnt >= FLOAT_WAIT - 1)
                begin
                    status_code <= `SCSS_ST_FLOAT_FAULT;
                    busy <= 1'b0;
                    state <= S_DONE;
                end
            end
            S_MAINS:
            begin
                // mains fault reported after waiting cleared
                if (!mains_freq_found)
                    status_code <= `SCSS_ST_MAINS_FAULT;
                nvm_page <= 1'b0;
                nvm_addr <= {AW{1'b0}};
                csum <= `SCSS_CSUM_OFFSET;
                nvm_rd <= 1'b1;
                state <= S_READ;
            end
            S_READ:
            begin
                // checksum accumulates over the page, offset seeded
                if (rd_pend)
                begin
                    csum <= csum + nvm_data;
                    if (nvm_addr == LAST)
                    begin
                        nvm_rd <= 1'b1;
                        nvm_addr <= LAST + {{(AW-1){1'b0}}, 1'b1};
                        state <= S_CHECK;
                    end
                    else
                    begin
                        nvm_addr <= nvm_addr + {{(AW-1){1'b0}}, 1'b1};
                        nvm_rd <= 1'b1;
                    end
                end
            end
            S_CHECK:
            begin
                // stored checksum byte follows the constants
                if (rd_pend)
                begin
                    if ((csum - nvm_data) == 8'h00 || nvm_page)
                    begin
                        // page two copied even if bad
                        nvm_addr <= {AW{1'b0}};
                        nvm_rd <= 1'b1;
                        ram_addr <= {AW{1'b0}};
                        state <= S_COPY;
                    end
                    else
                    begin
                        page_one_bad <= 1'b1;
                        nvm_page <= 1'b1;
                        nvm_addr <= {AW{1'b0}};
                        csum <= `SCSS_CSUM_OFFSET;
                        nvm_rd <= 1'b1;
                        state <= S_READ;
                    end
                end
            end
            S_COPY:
            begin
                // a default rewrite owns the ram port this cycle; fetch the word again
                if (rd_pend & chk_pend & ram_word_bad)
                    nvm_rd <= 1'b1;
                else if (rd_pend)
                begin
                    ram_we <= 1'b1;
                    ram_addr <= nvm_addr;
                    ram_wdata <= nvm_data;
                    if (nvm_addr == LAST)
                        state <= S_COUNT;
                    else
                    begin
                        nvm_addr <= nvm_addr + {{(AW-1){1'b0}}, 1'b1};
                        nvm_rd <= 1'b1;
                    end
                end
            end
            S_COUNT:
            begin
                // wait out the last word check and any default rewrite
                if (!chk_pend & !ram_we)
                begin
                    xfer_bad <= (ram_word_count != NCONST);
                    meas_func <= `SCSS_FUNC_DCV;
                    autorange <= 1'b1;
                    scale_len <= `SCSS_SCALE_6X9;
                    busy <= 1'b0;
                    state <= S_DONE;
                    // priority picks the single held code
                    if (!display_on)
                        status_code <= `SCSS_ST_DISPLAY_OFF;
                    else if (status_code == `SCSS_ST_MAINS_FAULT)
                        status_code <= `SCSS_ST_MAINS_FAULT;
                    else if (ram_word_count != NCONST)
                        status_code <= `SCSS_ST_XFER_FAIL;
                    else if (page_one_bad)
                        status_code <= `SCSS_ST_PAGE_ONE_BAD;
                    else if (defaults)
                        status_code <= `SCSS_ST_DEFAULTS_USED;
                    else if (backup_retained & !by_init)
                        status_code <= `SCSS_ST_RETAINED;
                    else
                        status_code <= `SCSS_ST_INITIALISED;
                end
            end
            S_DONE:
            begin
                // float fault is terminal until reset or init
                if (status_code != `SCSS_ST_FLOAT_FAULT | init_req)
                    state <= S_IDLE;
            end
            S_TEST:
            begin
                // stage status shown while it runs
                status_code <= `SCSS_ST_TEST_BASE + {3'h0, test_stage};
                test_start <= 1'b1;
                state <= S_TWAIT;
            end
            S_TWAIT:
            begin
                if (test_done)
                begin
                    if (!test_pass)
                    begin
                        status_code <= `SCSS_ST_FAIL_BASE + {3'h0, test_stage};
                        unusable <= ~test_stage[1];
                        dc_only <= test_stage[1];
                        busy <= 1'b0;
                        state <= S_IDLE;
                    end
                    else if (test_stage == 2'h3)
                    begin
                        status_code <= `SCSS_ST_PASS;
                        busy <= 1'b0;
                        state <= S_IDLE;
                    end
                    else
                    begin
                        test_stage <= test_stage + 2'h1;
                        state <= S_TEST;
                    end
                end
            end
            default:
                state <= S_IDLE;
            endcase
        end
    end

endmodule // scss_sequencer
`default_nettype wire

/* File: verification/scss_chk.sv */
/* Port checker for the startup sequencer: self-test order, codes, settings.
   Assumes one clock domain and the bind statement at the foot. */
`timescale 1ns/10ps
`default_nettype none
module scss_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       busy,
    input wire logic [4:0] status_code,
    input wire logic       test_start,
    input wire logic [1:0] test_stage,
    input wire logic       test_done,
    input wire logic       test_pass,
    input wire logic       unusable,
    input wire logic       dc_only,
    input wire logic [1:0] meas_func,
    input wire logic       autorange,
    input wire logic [1:0] scale_len,
    input wire logic       float_out_of_reset,
    input wire logic       nvm_rd,
    input wire logic       ram_we,
    input wire logic       ram_use_default,
    input wire logic       ram_word_bad
);
// ****************************
// stage memory and properties
// ****************************
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// stage of the latest start pulse, so codes can be tied to it
logic [1:0] last_stage;
always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
        last_stage <= 2'h0;
    else if (test_start)
        last_stage <= test_stage;
sequence s_fail;
    test_done && !test_pass;
endsequence
sequence s_last_pass;
    test_done && test_pass && last_stage == 2'h3;
endsequence
property p_stage_order;
    test_start && test_stage != 2'h0 |-> test_stage == last_stage + 2'h1;
endproperty
property p_stage_code;
    test_start |=> status_code == 5'h10 + {3'h0, last_stage};
endproperty
property p_fail_code;
    s_fail |-> ##[1:3] status_code == 5'h14 + {3'h0, last_stage};
endproperty
property p_fail_stop;
    s_fail |=> (!test_start) [*4];
endproperty
property p_pass_code;
    s_last_pass |-> ##[1:3] status_code == 5'h18;
endproperty
property p_fail_limits;
    s_fail |-> ##[1:3] (unusable == (last_stage < 2'h2) && dc_only == (last_stage >= 2'h2));
endproperty
property p_defaults;
    $fell(busy) |-> meas_func == 2'h0 && autorange && scale_len == 2'h1;
endproperty
property p_float_first;
    !float_out_of_reset && busy |-> !nvm_rd;
endproperty
property p_default_rewrite;
    ram_word_bad |-> ##[0:2] (ram_we && ram_use_default);
endproperty
a_stage_order: assert property (p_stage_order)
    else $error("self test stage out of order");
a_stage_code: assert property (p_stage_code)
    else $error("running stage code wrong");
a_fail_code: assert property (p_fail_code)
    else $error("failing stage code wrong");
a_fail_stop: assert property (p_fail_stop)
    else $error("stage started after a failure");
a_pass_code: assert property (p_pass_code)
    else $error("pass code missing");
a_fail_limits: assert property (p_fail_limits)
    else $error("usability flags wrong after failure");
a_defaults: assert property (p_defaults)
    else $error("default settings missing at end");
a_float_first: assert property (p_float_first)
    else $error("store read before isolated side ready");
a_default_rewrite: assert property (p_default_rewrite)
    else $error("bad word not rewritten with default");
endmodule // scss_chk
bind scss_sequencer scss_chk u_chk (
    .pclk(pclk), .presetn(presetn), .busy(busy), .status_code(status_code),
    .test_start(test_start), .test_stage(test_stage), .test_done(test_done),
    .test_pass(test_pass), .unusable(unusable), .dc_only(dc_only), .meas_func(meas_func),
    .autorange(autorange), .scale_len(scale_len), .float_out_of_reset(float_out_of_reset),
    .nvm_rd(nvm_rd), .ram_we(ram_we), .ram_use_default(ram_use_default),
    .ram_word_bad(ram_word_bad)
);
`default_nettype wire

/* File: verification/scss_partner.sv */
/* Far side model: two-page store, backed RAM with word check and count,
   and the isolated measurement side that runs each self-test stage.
   Assumes the testbench sets the fault controls between sequences. */
`timescale 1ns/10ps
`default_nettype none
module scss_partner #(
    parameter int AW     = 6,
    parameter int NCONST = 8
) (
    input wire logic          pclk,
    input wire logic          nvm_rd,
    input wire logic          nvm_page,
    input wire logic [AW-1:0] nvm_addr,
    output var logic [7:0]    nvm_data,
    input wire logic          ram_we,
    input wire logic [AW-1:0] ram_addr,
    input wire logic [7:0]    ram_wdata,
    input wire logic          ram_use_default,
    output var logic          ram_word_bad,
    output var logic [AW:0]   ram_word_count,
    input wire logic          test_start,
    input wire logic [1:0]    test_stage,
    output var logic          test_done,
    output var logic          test_pass,
    input wire logic          page_one_empty,
    input wire logic          page_two_bad,
    input wire logic          bad_en,
    input wire logic [AW-1:0] bad_idx,
    input wire logic          short_cnt,
    input wire logic [2:0]    fail_stage
);
logic [7:0]  ram [0:(1<<AW)-1];
logic [AW:0] cnt   = '0;
logic [1:0]  tcnt  = 2'h0;
// ****************************
// store pages
// ****************************
// both pages hold the same constants, except page one reads all zero when set empty
function automatic logic [7:0] nvm_byte(input logic pg, input logic [AW-1:0] a);
    logic [7:0] s;
    s = 8'h5a;
    for (int i = 0; i < NCONST; i++)
        s = s + 8'h30 + i[7:0];
    if (!pg && page_one_empty)
        nvm_byte = 8'h00;
    else if (a < NCONST)
        nvm_byte = 8'h30 + 8'(a);
    else
        nvm_byte = s + {7'h0, pg & page_two_bad};
endfunction
// data valid one cycle after the strobe, toggling junk otherwise
always @(posedge pclk)
    nvm_data <= nvm_rd ? nvm_byte(nvm_page, nvm_addr) : ~nvm_data;
// ****************************
// backed RAM and test side
// ****************************
// count restarts when a page read begins
always @(posedge pclk)
begin
    if (ram_we)
        ram[ram_addr] <= ram_wdata;
    ram_word_bad <= ram_we && !ram_use_default && bad_en && ram_addr == bad_idx;
    if (nvm_rd && nvm_addr == '0)
        cnt <= '0;
    else if (ram_we && !ram_use_default)
        cnt <= cnt + 1'b1;
end
assign ram_word_count = cnt - {{AW{1'b0}}, short_cnt};
// each stage answers four cycles after its start
always @(posedge pclk)
begin
    test_done <= tcnt == 2'h1;
    test_pass <= tcnt == 2'h1 && {1'b0, test_stage} != fail_stage;
    if (test_start)
        tcnt <= 2'h3;
    else if (tcnt != 2'h0)
        tcnt <= tcnt - 2'h1;
end
endmodule // scss_partner
`default_nettype wire

/* File: verification/scss_tb.sv */
/* Testbench for the startup sequencer: power-up, store fallback, count and
   default faults, self test and display control over APB.
   Assumes the partner model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
`include "scss_consts.vh"
module testbench;
logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic        pready, pslverr, err, flt = 1'b1, mains = 1'b1, bkp = 1'b1;
logic        nvm_rd, nvm_page, ram_we, ram_use_default, ram_word_bad, test_start, test_done;
logic        test_pass, display_on, autorange, unusable, dc_only, busy;
logic [5:0]  nvm_addr, ram_addr;
logic [6:0]  ram_word_count;
logic [7:0]  nvm_data, ram_wdata;
logic [1:0]  test_stage, meas_func, scale_len;
logic [4:0]  status_code;
logic        p1e = 1'b0, p2b = 1'b0, bad_en = 1'b0, short_cnt = 1'b0;
logic [5:0]  bad_idx = 6'h03;
logic [2:0]  fail_stage = 3'h4;
int          errors = 0, tests_run = 0;
scss_sequencer #(.AW(6), .NCONST(8), .FLOAT_WAIT(20)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .float_out_of_reset(flt), .mains_freq_found(mains), .backup_retained(bkp),
    .nvm_rd(nvm_rd), .nvm_page(nvm_page), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_use_default(ram_use_default),
    .ram_word_bad(ram_word_bad), .ram_word_count(ram_word_count), .test_start(test_start),
    .test_stage(test_stage), .test_done(test_done), .test_pass(test_pass),
    .status_code(status_code), .display_on(display_on), .meas_func(meas_func),
    .autorange(autorange), .scale_len(scale_len), .unusable(unusable), .dc_only(dc_only),
    .busy(busy));
scss_partner #(.AW(6), .NCONST(8)) u_far (
    .pclk(pclk), .nvm_rd(nvm_rd), .nvm_page(nvm_page), .nvm_addr(nvm_addr),
    .nvm_data(nvm_data), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_use_default(ram_use_default), .ram_word_bad(ram_word_bad),
    .ram_word_count(ram_word_count), .test_start(test_start), .test_stage(test_stage),
    .test_done(test_done), .test_pass(test_pass), .page_one_empty(p1e),
    .page_two_bad(p2b), .bad_en(bad_en), .bad_idx(bad_idx), .short_cnt(short_cnt),
    .fail_stage(fail_stage));
// ****************************
// clock and tasks
// ****************************
always #2.5 pclk = ~pclk;
task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
        errors++;
        $display("Error %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
// one apb transfer; an idle edge follows so psel never re-rises in one step
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
        @(posedge pclk);
        n++;
    end
    check(32'(pready), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
// wait for a sequence to start and end, then compare its code
task automatic run(input logic [4:0] exp);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 10)
    begin
        @(posedge pclk);
        n++;
    end
    check(32'(busy), 32'h1);
    while (busy !== 1'b0 && n < 5000)
    begin
        @(posedge pclk);
        n++;
    end
    check(32'(busy), 32'h0);
    check(32'(status_code), 32'(exp));
    $display("sequence ends at %0t", $time);
endtask
task automatic do_reset;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check(32'({busy, status_code}), 32'h21);
endtask
// ****************************
// scenarios
// ****************************
initial
begin
    do_reset;
    run(`SCSS_ST_RETAINED);
    check(32'({meas_func, autorange, scale_len}), 32'h05);
    check(32'(u_far.ram[7]), 32'h37);
    apb(1'b0, `SCSS_REG_RESULT, 32'h0);
    check(rd, 32'(`SCSS_ST_RETAINED));
    apb(1'b0, 12'h020, 32'h0);
    check({rd[30:0], err}, 32'h1);
    p1e <= 1'b1;
    apb(1'b1, `SCSS_REG_CTRL, 32'h1);
    run(`SCSS_ST_PAGE_ONE_BAD);
    check(32'(u_far.ram[1]), 32'h31);
    p2b <= 1'b1;
    u_far.ram[0] = 8'h00;
    apb(1'b1, `SCSS_REG_CTRL, 32'h1);
    run(`SCSS_ST_PAGE_ONE_BAD);
    check(32'(u_far.ram[0]), 32'h30);
    p1e <= 1'b0;
    p2b <= 1'b0;
    bad_en <= 1'b1;
    apb(1'b1, `SCSS_REG_CTRL, 32'h1);
    run(`SCSS_ST_DEFAULTS_USED);
    bad_idx <= 6'h07;
    apb(1'b1, `SCSS_REG_CTRL, 32'h1);
    run(`SCSS_ST_DEFAULTS_USED);
    bad_en <= 1'b0;
    short_cnt <= 1'b1;
    apb(1'b1, `SCSS_REG_CTRL, 32'h1);
    run(`SCSS_ST_XFER_FAIL);
    short_cnt <= 1'b0;
    apb(1'b1, `SCSS_REG_CTRL, 32'h1);
    run(`SCSS_ST_INITIALISED);
    bkp <= 1'b0;
    do_reset;
    run(`SCSS_ST_INITIALISED);
    bkp <= 1'b1;
    mains <= 1'b0;
    do_reset;
    run(`SCSS_ST_MAINS_FAULT);
    mains <= 1'b1;
    flt <= 1'b0;
    do_reset;
    run(`SCSS_ST_FLOAT_FAULT);
    flt <= 1'b1;
    apb(1'b1, `SCSS_REG_CTRL, 32'h1);
    run(`SCSS_ST_INITIALISED);
    apb(1'b1, `SCSS_REG_CTRL, 32'h8);
    check(32'(display_on), 32'h0);
    apb(1'b1, `SCSS_REG_CTRL, 32'h4);
    check(32'(display_on), 32'h1);
    apb(1'b1, `SCSS_REG_CTRL, 32'h2);
    run(`SCSS_ST_PASS);
    check(32'({unusable, dc_only}), 32'h0);
    // every stage made to fail in turn
    for (int s = 0; s < 4; s++)
    begin
        fail_stage <= 3'(s);
        apb(1'b1, `SCSS_REG_CTRL, 32'h2);
        run(`SCSS_ST_FAIL_BASE + 5'(s));
        check(32'({unusable, dc_only}), (s < 2) ? 32'h2 : 32'h1);
    end
    end_sim;
end
// hang guard, well beyond the expected run
initial
begin
    #400000;
    errors++;
    $display("Error %0t: watchdog expired", $time);
    end_sim;
end
endmodule // testbench
`default_nettype wire
